// ==== src/voice_chain.sv ====
// Analogue voice and sub-audio processing chain with Wishbone register slave
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "voice_chain_defines.svh"
module voice_chain
  import voice_chain_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               rx_mode_i,
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] sample_i,
  output logic                    sample_valid_o,
  output logic signed [15:0]      sample_o,
  output logic [3:0]              in1_gain_o,
  output level_t                  level_o,
  output logic [7:0]              tx_code_o,
  output code_kind_t              tx_code_kind_o,
  input  wire logic               rx_code_valid_i,
  input  wire logic [7:0]         rx_code_i
);
  // Saturate a 17-bit intermediate to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
    if (v > 17'sh07fff)
      sat16 = 16'sh7fff;
    else if (v < -17'sh08000)
      sat16 = 16'sh8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // Magnitude, saturated so the most negative sample does not wrap
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? sat16(-{v[15], v}) : v;
  endfunction : mag16

  // Classify a sub-audio code value
  function automatic code_kind_t classify(input logic [7:0] c);
    if (c == `DCS_NONE)
      classify = KIND_NONE;
    else if (c <= `DCS_TRUE_MAX)
      classify = KIND_DCS;
    else if (c >= `DCS_INV_OFS && c <= `DCS_INV_MAX)
      classify = KIND_DCS;
    else if (c >= `CTCSS_MIN)
      classify = KIND_CTCSS;
    else
      classify = KIND_BAD;
  endfunction : classify

  // Merge a write into a 16-bit register under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic [15:0]        ctrl_reg;
  logic [15:0]        actrl_reg;
  logic [15:0]        amode_reg;
  logic [15:0]        fsel_reg;
  logic [15:0]        lim_thr_reg;
  logic [15:0]        tx_unity_reg;
  logic [15:0]        rx_unity_reg;
  logic [15:0]        agc_thr_reg;
  logic [15:0]        agc_maxdec_reg;
  logic [3:0]         in1_gain_reg;
  logic [7:0]         rx_code_reg;
  logic [3:0]         agc_gain_reg;
  logic [11:0]        decay_cnt_reg;
  agc_state_t         agc_state_reg;
  logic [15:0]        env_reg;
  logic [15:0]        phase_reg;
  logic [4:0]         valid_pipe_reg;
  logic               ack_reg;
  logic [31:0]        rdata_reg;
  logic signed [15:0] comp_reg;
  logic signed [15:0] lim_reg;
  logic signed [15:0] scr_reg;
  logic signed [15:0] hpf_out;
  logic signed [15:0] chan_out;
  logic signed [15:0] splat_out;
  logic [2:0]         chan_shift;
  logic [15:0]        scr_inc;
  logic [15:0]        comp_unity;
  logic [15:0]        in_mag;
  logic               wr_strobe;
  stage_ctrl_t        stage;
  level_t             lvl;

  assign stage     = stage_ctrl_t'(ctrl_reg[6:0]);
  assign lvl       = '{voice:  actrl_reg[`ACTRL_VOICE],
                       inband: actrl_reg[`ACTRL_INBAND],
                       subaud: actrl_reg[`ACTRL_SUBAUD]};
  assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

  // Bus acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end
  assign wb_ack_o = ack_reg;

  // Software-written registers; unmapped writes are ignored
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl_reg       <= `RST_CTRL;
      actrl_reg      <= `RST_ACTRL;
      amode_reg      <= '0;
      fsel_reg       <= `RST_FSEL;
      lim_thr_reg    <= `RST_LIM_THR;
      tx_unity_reg   <= `RST_UNITY;
      rx_unity_reg   <= `RST_UNITY;
      agc_thr_reg    <= `RST_AGC_THR;
      agc_maxdec_reg <= `RST_AGC_MAXDEC;
      in1_gain_reg   <= `RST_IN1_GAIN;
    end
    else if (wr_strobe)
    begin
      case (wb_adr_i)
        `OFS_CTRL:       ctrl_reg       <= merge16(ctrl_reg, wb_dat_i, wb_sel_i);
        `OFS_ACTRL:      actrl_reg      <= merge16(actrl_reg, wb_dat_i, wb_sel_i);
        `OFS_AMODE:      amode_reg      <= merge16(amode_reg, wb_dat_i, wb_sel_i);
        `OFS_FSEL:       fsel_reg       <= merge16(fsel_reg, wb_dat_i, wb_sel_i);
        `OFS_LIM_THR:    lim_thr_reg    <= merge16(lim_thr_reg, wb_dat_i, wb_sel_i);
        `OFS_TX_UNITY:   tx_unity_reg   <= merge16(tx_unity_reg, wb_dat_i, wb_sel_i);
        `OFS_RX_UNITY:   rx_unity_reg   <= merge16(rx_unity_reg, wb_dat_i, wb_sel_i);
        `OFS_AGC_THR:    agc_thr_reg    <= merge16(agc_thr_reg, wb_dat_i, wb_sel_i);
        `OFS_AGC_MAXDEC: agc_maxdec_reg <= merge16(agc_maxdec_reg, wb_dat_i, wb_sel_i);
        `OFS_IN1_GAIN:
        begin
          // Direct gain writes still land but only steer the amp with gain control off
          if (wb_sel_i[0])
            in1_gain_reg <= wb_dat_i[3:0];
        end
        default:         ;
      endcase
    end
  end

  // Read mux, registered alongside the acknowledge; unmapped reads return zero
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_reg <= '0;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg)
    begin
      case (wb_adr_i)
        `OFS_CTRL:       rdata_reg <= {16'h0000, ctrl_reg};
        `OFS_ACTRL:      rdata_reg <= {16'h0000, actrl_reg};
        `OFS_AMODE:      rdata_reg <= {16'h0000, amode_reg};
        `OFS_ASTAT:      rdata_reg <= {18'h00000, agc_gain_reg, classify(rx_code_reg),
                                       rx_code_reg};
        `OFS_FSEL:       rdata_reg <= {16'h0000, fsel_reg};
        `OFS_LIM_THR:    rdata_reg <= {16'h0000, lim_thr_reg};
        `OFS_TX_UNITY:   rdata_reg <= {16'h0000, tx_unity_reg};
        `OFS_RX_UNITY:   rdata_reg <= {16'h0000, rx_unity_reg};
        `OFS_AGC_THR:    rdata_reg <= {16'h0000, agc_thr_reg};
        `OFS_AGC_MAXDEC: rdata_reg <= {16'h0000, agc_maxdec_reg};
        `OFS_IN1_GAIN:   rdata_reg <= {28'h0000000, in1_gain_reg};
        default:         rdata_reg <= '0;
      endcase
    end
  end
  assign wb_dat_o = rdata_reg;

  // Receive sub-audio code captured for the status register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rx_code_reg <= '0;
    else if (rx_code_valid_i)
      rx_code_reg <= rx_code_i;
  end

  // Transmit code straight from the mode register
  assign tx_code_o      = amode_reg[7:0];
  assign tx_code_kind_o = classify(amode_reg[7:0]);
  assign level_o        = lvl;

  // Stage 1: 300 Hz high-pass ahead of everything else
  iir_stage u_hpf (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .valid_i   (sample_valid_i),
    .en_i      (stage.hpf_en),
    .hp_i      (1'b1),
    .shift_i   (`HPF_SHIFT),
    .data_i    (sample_i),
    .data_o    (hpf_out)
  );

  // Narrow unless the wide bit is set
  assign chan_shift = fsel_reg[`FSEL_WIDE] ? `WIDE_SHIFT : `NARROW_SHIFT;

  // Stage 2: channel filter
  iir_stage u_chan (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .valid_i   (valid_pipe_reg[0]),
    .en_i      (stage.chan_en),
    .hp_i      (1'b0),
    .shift_i   (chan_shift),
    .data_i    (hpf_out),
    .data_o    (chan_out)
  );

  // Syllabic envelope of the compander input; the step is signed so a falling level decays
  assign in_mag = mag16(chan_out);
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      env_reg <= '0;
    else if (valid_pipe_reg[1])
      env_reg <= 16'($signed({1'b0, env_reg})
                     + ($signed(17'(in_mag) - 17'(env_reg)) >>> `ENV_SHIFT));
  end

  // Stage 3: 2:1 compress in transmit, 1:2 expand in receive about unity point
  assign comp_unity = rx_mode_i ? rx_unity_reg : tx_unity_reg;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      comp_reg <= '0;
    else if (valid_pipe_reg[1])
    begin
      if (!stage.comp_en)
        comp_reg <= chan_out;
      else if ((env_reg > comp_unity) != rx_mode_i)
        comp_reg <= chan_out >>> 1;
      else if (env_reg < (comp_unity >> 1) || (env_reg > comp_unity))
        comp_reg <= sat16({chan_out, 1'b0});
      else
        comp_reg <= chan_out;
    end
  end

  // Stage 4: hard limiter; clipping bounds peak deviation
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      lim_reg <= '0;
    else if (valid_pipe_reg[2])
    begin
      if (stage.lim_en && $signed({1'b0, lim_thr_reg}) < 17'(comp_reg))
        lim_reg <= lim_thr_reg;
      else if (stage.lim_en && -$signed({1'b0, lim_thr_reg}) > 17'(comp_reg))
        lim_reg <= sat16(-$signed({1'b0, lim_thr_reg}));
      else
        lim_reg <= comp_reg;
    end
  end

  // Stage 5: anti-splatter low-pass removes clipping harmonics
  iir_stage u_splat (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .valid_i   (valid_pipe_reg[3]),
    .en_i      (stage.splat_en),
    .hp_i      (1'b0),
    .shift_i   (`SPLAT_SHIFT),
    .data_i    (lim_reg),
    .data_o    (splat_out)
  );

  // Scrambler carrier increment from the control field
  assign scr_inc = 16'(`SCR_BASE_INC + `SCR_STEP_INC * actrl_reg[`ACTRL_SCR]);

  // Carrier phase advances once per sample, only while scrambling
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      phase_reg <= '0;
    else if (valid_pipe_reg[4] && stage.scr_en)
      phase_reg <= phase_reg + scr_inc;
  end

  // Stage 6: square-carrier mix inverts the spectrum, then voice level shift
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      scr_reg <= '0;
    else if (valid_pipe_reg[4])
    begin
      if (stage.scr_en && phase_reg[15])
        scr_reg <= sat16(-17'(splat_out)) >>> lvl.voice;
      else
        scr_reg <= splat_out >>> lvl.voice;
    end
  end
  assign sample_o = scr_reg;

  // One stage per cycle behind the input strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      valid_pipe_reg <= '0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      valid_pipe_reg <= {valid_pipe_reg[3:0], sample_valid_i};
      sample_valid_o <= valid_pipe_reg[4];
    end
  end

  // Microphone gain control state machine on raw input peaks
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      agc_state_reg <= AGC_OFF;
      agc_gain_reg  <= '0;
      decay_cnt_reg <= '0;
    end
    else
    begin
      case (agc_state_reg)
        AGC_OFF:
        begin
          agc_gain_reg  <= in1_gain_reg;
          decay_cnt_reg <= '0;
          if (stage.agc_en)
            agc_state_reg <= AGC_TRACK;
        end
        AGC_TRACK:
        begin
          if (!stage.agc_en)
            agc_state_reg <= AGC_OFF;
          else if (sample_valid_i && mag16(sample_i) > agc_thr_reg)
          begin
            if (agc_gain_reg != 4'h0)
              agc_gain_reg <= agc_gain_reg - 4'h1;
            decay_cnt_reg <= '0;
          end
          else if (sample_valid_i)
          begin
            if (decay_cnt_reg >= agc_maxdec_reg[`MAXDEC_TIME])
              agc_state_reg <= AGC_DECAY;
            else
              decay_cnt_reg <= decay_cnt_reg + 12'h001;
          end
        end
        AGC_DECAY:
        begin
          // Gain recovers by one step, never above the programmed ceiling
          if (agc_gain_reg < agc_maxdec_reg[`MAXDEC_GAIN])
            agc_gain_reg <= agc_gain_reg + 4'h1;
          decay_cnt_reg <= '0;
          agc_state_reg <= stage.agc_en ? AGC_TRACK : AGC_OFF;
        end
        default:
          agc_state_reg <= AGC_OFF;
      endcase
    end
  end

  // Amp gain follows gain control when enabled, otherwise the direct register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      in1_gain_o <= `RST_IN1_GAIN;
    else if (agc_state_reg != AGC_OFF)
      in1_gain_o <= agc_gain_reg;
    else
      in1_gain_o <= in1_gain_reg;
  end
endmodule : voice_chain

// ==== src/voice_chain_defines.svh ====
// Register offsets, field positions, reset values and timing for the voice chain
`ifndef VOICE_CHAIN_DEFINES_SVH
`define VOICE_CHAIN_DEFINES_SVH
// Byte addresses on the register bus
`define OFS_CTRL        8'h00
`define OFS_ACTRL       8'h04
`define OFS_AMODE       8'h08
`define OFS_ASTAT       8'h0c
`define OFS_FSEL        8'h10
`define OFS_LIM_THR     8'h14
`define OFS_TX_UNITY    8'h18
`define OFS_RX_UNITY    8'h1c
`define OFS_AGC_THR     8'h20
`define OFS_AGC_MAXDEC  8'h24
`define OFS_IN1_GAIN    8'h28
// Reset values
`define RST_CTRL        16'h0000
`define RST_ACTRL       16'h9000
`define RST_FSEL        16'h0000
`define RST_LIM_THR     16'h4000
`define RST_UNITY       16'h1000
`define RST_AGC_THR     16'h2000
`define RST_AGC_MAXDEC  16'h0ff8
`define RST_IN1_GAIN    4'h0
// Analogue control fields
`define ACTRL_VOICE     3:0
`define ACTRL_INBAND    7:4
`define ACTRL_SUBAUD    11:8
`define ACTRL_SCR       15:12
`define FSEL_WIDE       0
`define MAXDEC_GAIN     3:0
`define MAXDEC_TIME     15:4
// Sub-audio code encoding
`define DCS_NONE        8'h00
`define DCS_TRUE_MAX    8'h54
`define DCS_INV_OFS     8'h64
`define DCS_INV_MAX     8'hb8
`define CTCSS_MIN       8'hc8
// Filter shifts (first-order sections at the internal rate)
`define SAMPLE_RATE_HZ  8000
`define HPF_SHIFT       3'h2
`define NARROW_SHIFT    3'h2
`define WIDE_SHIFT      3'h1
`define SPLAT_SHIFT     3'h1
`define ENV_SHIFT       4
// Scrambler carrier: base plus code times step, in Hz
`define SCR_BASE_HZ     2400
`define SCR_STEP_HZ     100
`define SCR_BASE_INC    16'(((`SCR_BASE_HZ) * 65536) / (`SAMPLE_RATE_HZ))
`define SCR_STEP_INC    16'(((`SCR_STEP_HZ) * 65536) / (`SAMPLE_RATE_HZ))
`endif

// ==== src/voice_chain_pkg.sv ====
// Types shared by the voice chain design
package voice_chain_pkg;
  typedef struct packed {
    logic hpf_en;
    logic chan_en;
    logic comp_en;
    logic lim_en;
    logic splat_en;
    logic scr_en;
    logic agc_en;
  } stage_ctrl_t;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_DCS,
    KIND_CTCSS,
    KIND_BAD
  } code_kind_t;

  typedef enum logic [1:0] {
    AGC_OFF,
    AGC_TRACK,
    AGC_DECAY
  } agc_state_t;

  typedef struct packed {
    logic [3:0] voice;
    logic [3:0] inband;
    logic [3:0] subaud;
  } level_t;
endpackage : voice_chain_pkg

// ==== src/iir_stage.sv ====
// One-pole filter section, low-pass or high-pass, with bypass
`timescale 1ns/1ps
module iir_stage
  import voice_chain_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               valid_i,
  input  wire logic               en_i,
  input  wire logic               hp_i,
  input  wire logic [2:0]         shift_i,
  input  wire logic signed [15:0] data_i,
  output logic signed [15:0]      data_o
);
  logic signed [19:0] acc_reg;
  logic signed [19:0] x_ext;
  logic signed [19:0] hp_val;

  assign x_ext  = {data_i, 4'h0};
  assign hp_val = x_ext - acc_reg;

  // Low-pass state follows the input even in bypass so enabling causes no step
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      acc_reg <= '0;
    else if (valid_i)
      acc_reg <= acc_reg + (hp_val >>> shift_i);
  end

  // Output stage registered once per sample
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      data_o <= '0;
    else if (valid_i)
    begin
      if (!en_i)
        data_o <= data_i;
      else if (hp_i)
        data_o <= hp_val[19:4];
      else
        data_o <= acc_reg[19:4];
    end
  end
endmodule : iir_stage

// ==== dv/voice_chain_assertions.sv ====
// Port-level assertions for the voice chain
`timescale 1ns/1ps
`include "voice_chain_defines.svh"
module voice_chain_assertions
  import voice_chain_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               sample_valid_i,
  input wire logic               sample_valid_o,
  input wire logic signed [15:0] sample_o,
  input wire logic [3:0]         in1_gain_o,
  input wire level_t             level_o,
  input wire logic [7:0]         tx_code_o,
  input wire code_kind_t         tx_code_kind_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Full-width write seen in its ack cycle; the request is still held there
  wire logic wr_ok = wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3;

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `OFS_IN1_GAIN |->
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  level_map_a: assert property (wr_ok && wb_adr_i == `OFS_ACTRL |->
    level_o == {wb_dat_i[3:0], wb_dat_i[7:4], wb_dat_i[11:8]}) else $error("level fields wrong");
  tx_code_a: assert property (wr_ok && wb_adr_i == `OFS_AMODE |->
    tx_code_o == wb_dat_i[7:0]) else $error("tx code not from mode register");
  dcs_kind_a: assert property (tx_code_o inside {[8'h01:8'h54], [8'h65:8'hb8]} |->
    tx_code_kind_o == KIND_DCS) else $error("dcs code misclassified");
  none_kind_a: assert property (tx_code_o == 8'h00 |-> tx_code_kind_o == KIND_NONE)
    else $error("no-code misclassified");
  tone_kind_a: assert property (tx_code_o inside {[8'hc9:8'hfc]} |->
    tx_code_kind_o == KIND_CTCSS) else $error("tone code misclassified");
  // A direct gain write or gain control switched off moves the gain up to two cycles after ack
  gain_step_a: assert property (!$past(wb_ack_o) && !$past(wb_ack_o, 2) |->
    4'(in1_gain_o - $past(in1_gain_o)) inside {4'h0, 4'h1, 4'hf}) else $error("gain jumped");
  sample_lat_a: assert property (sample_valid_i |-> ##6 sample_valid_o)
    else $error("sample latency not six");
  sample_only_a: assert property (sample_valid_o |-> $past(sample_valid_i, 6))
    else $error("spurious output sample");
  sample_hold_a: assert property (!sample_valid_o |-> $stable(sample_o))
    else $error("sample changed without valid");

  // Main scenarios reached
  cover property (wr_ok && wb_adr_i == `OFS_ACTRL);
  cover property (sample_valid_o && sample_o != 16'sh0);
  cover property (tx_code_kind_o == KIND_CTCSS);
endmodule : voice_chain_assertions

bind voice_chain voice_chain_assertions chk (.*);

// ==== dv/wb_host_model.sv ====
// Wishbone host model that programs the voice chain registers
`timescale 1ns/1ps
`include "voice_chain_defines.svh"
module wb_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  logic agc_on;
  // Idle bus at time zero
  initial
  begin
    agc_on = 1'b0;
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // Classic cycle: held until ack is sampled, released at that same edge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= 4'h3;
    wb_dat_o <= {16'h0, d};
    do @(posedge clk_sys_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o; // Released data must not pass for valid
  endtask : xfer
  // Gain writes are withheld while gain control owns the amplifier
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    if (a == `OFS_IN1_GAIN && agc_on) return;
    if (a == `OFS_CTRL) agc_on = d[0];
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 16'h0, q);
  endtask : rd
endmodule : wb_host_model

// ==== dv/tb_voice_chain.sv ====
// Self-checking bench for the voice chain
`timescale 1ns/1ps
`include "voice_chain_defines.svh"
module tb_voice_chain;
  import voice_chain_pkg::*;
  logic clk_sys_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_mode_i;
  logic [7:0] wb_adr_i, tx_code_o, rx_code_i;
  logic [3:0] wb_sel_i, in1_gain_o, g;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic sample_valid_i, sample_valid_o, rx_code_valid_i;
  logic signed [15:0] sample_i, sample_o, x, y, t, pn, pw;
  level_t level_o;
  code_kind_t tx_code_kind_o;
  int n_fail, checked, cycles, lat, seed, nneg;
  logic [7:0] ra [10] = '{`OFS_CTRL, `OFS_ACTRL, `OFS_FSEL, `OFS_LIM_THR, `OFS_TX_UNITY,
    `OFS_RX_UNITY, `OFS_AGC_THR, `OFS_AGC_MAXDEC, `OFS_IN1_GAIN, 8'h40};
  logic [15:0] rv [10] = '{`RST_CTRL, `RST_ACTRL, `RST_FSEL, `RST_LIM_THR, `RST_UNITY,
    `RST_UNITY, `RST_AGC_THR, `RST_AGC_MAXDEC, 16'h0, 16'h0};
  logic [7:0] codes [15] = '{8'h00, 8'h01, 8'h2a, 8'h53, 8'h54, 8'h65, 8'h96, 8'hb8,
    8'hc9, 8'he6, 8'hfc, 8'h55, 8'h63, 8'hb9, 8'hc7};
  logic [15:0] ctl [3] = '{16'h0000, 16'h0008, 16'h000c};

  voice_chain dut (.*);
  wb_host_model host (.clk_sys_i(clk_sys_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
    .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Expected code class; 100, 200 and 253-255 are left out as special cases
  function automatic code_kind_t kind_of(input logic [7:0] c);
    if (c == 8'h00) return KIND_NONE;
    if (c <= 8'h54 || (c >= 8'h65 && c <= 8'hb8)) return KIND_DCS;
    if (c >= 8'hc9 && c <= 8'hfc) return KIND_CTCSS;
    return KIND_BAD;
  endfunction : kind_of
  function automatic logic signed [15:0] clip(input logic signed [15:0] v, th);
    return (v > th) ? th : (v < -th) ? -th : v;
  endfunction : clip
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One sample in; lat counts edges until the output pulse is seen
  task automatic send(input logic signed [15:0] v, output logic signed [15:0] r);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b1;
    sample_i <= v;
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b0;
    lat = 0;
    while (sample_valid_o !== 1'b1 && lat < 9)
    begin
      @(posedge clk_sys_i);
      lat++;
    end
    r = sample_o;
  endtask : send
  task end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 32'ha160;
    {rst_i, sample_valid_i, sample_i, rx_code_valid_i, rx_code_i} = '1;
    {sample_valid_i, rx_code_valid_i} = 2'b00;
    rx_mode_i = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rx_mode_i <= 1'($random(seed));
    chk(level_o, 12'h000);
    foreach (ra[i])
    begin
      host.rd(ra[i], q);
      chk(q, {16'h0, rv[i]});
    end
    for (int i = 1; i < 8; i++)
    begin
      x = 16'($random(seed));
      if (ra[i] == `OFS_FSEL) x[15:1] = '0;
      host.wr(ra[i], x);
      host.rd(ra[i], q);
      chk(q, {16'h0, x});
      if (i == 1) chk(level_o, {x[3:0], x[7:4], x[11:8]});
    end
    host.wr(`OFS_CTRL, 16'h0040);
    foreach (codes[i])
    begin
      host.wr(`OFS_AMODE, {8'h00, codes[i]});
      chk(tx_code_o, codes[i]);
      chk(tx_code_kind_o, kind_of(codes[i]));
      @(posedge clk_sys_i);
      rx_code_valid_i <= 1'b1;
      rx_code_i <= codes[i];
      @(posedge clk_sys_i);
      rx_code_valid_i <= 1'b0;
      host.rd(`OFS_ASTAT, q);
      chk(q[9:0], {kind_of(codes[i]), codes[i]});
    end
    host.wr(`OFS_ASTAT, 16'hffff);
    host.rd(`OFS_ASTAT, q);
    chk(q[9:0], {kind_of(8'hc7), 8'hc7});
    // Limiter and its smoothing stage against a random threshold
    host.wr(`OFS_ACTRL, 16'h9000);
    t = {3'b001, 13'($random(seed))};
    host.wr(`OFS_LIM_THR, t);
    foreach (ctl[m])
    begin
      host.wr(`OFS_CTRL, ctl[m]);
      for (int i = 0; i < 12; i++)
      begin
        x = (i == 0) ? t : (i == 1) ? -t - 16'sh1 : 16'($random(seed)) >>> 1;
        send(x, y);
        chk(lat, 6);
        if (m == 0) chk(y, x);
        if (m == 1) chk(y, clip(x, t));
        if (m == 2) chk(y > t || y < -t, 1'b0);
      end
    end
    // Steady input must be stripped by the high-pass
    host.wr(`OFS_CTRL, 16'h0040);
    repeat (16) send(16'sh4000, y);
    chk(y < 16'sh0800 && y > -16'sh0800, 1'b1);
    // Tone at half the sample rate: narrow must cut deeper than wide
    host.wr(`OFS_CTRL, 16'h0020);
    for (int f = 0; f < 2; f++)
    begin
      host.wr(`OFS_FSEL, 16'(f));
      pw = 16'sh0;
      for (int i = 0; i < 24; i++)
      begin
        send(i[0] ? -16'sh4000 : 16'sh4000, y);
        if (i > 15 && (y > pw || -y > pw)) pw = (y < 0) ? -y : y;
      end
      if (f == 0) pn = pw;
    end
    chk(pn < pw && pw < 16'sh4000, 1'b1);
    // Gain control pulls the amplifier down, then decays back to its ceiling
    host.wr(`OFS_CTRL, 16'h0000);
    g = 4'($random(seed));
    host.wr(`OFS_IN1_GAIN, {12'h0, g});
    @(posedge clk_sys_i);
    chk(in1_gain_o, g);
    host.wr(`OFS_AGC_THR, `RST_AGC_THR);
    host.wr(`OFS_AGC_MAXDEC, 16'h0023);
    host.wr(`OFS_CTRL, 16'h0001);
    repeat (20) send(16'sh7000, y);
    chk(in1_gain_o, 4'h0);
    repeat (24) send(16'sh0100, y);
    chk(in1_gain_o, 4'h3);
    host.wr(`OFS_IN1_GAIN, 16'h000f);
    host.wr(`OFS_CTRL, 16'h0000);
    repeat (2) @(posedge clk_sys_i);
    chk(in1_gain_o, g);
    // Scrambler flips the sign of some samples; voice level halves them all
    host.wr(`OFS_ACTRL, 16'h9001);
    host.wr(`OFS_CTRL, 16'h0002);
    nneg = 0;
    repeat (8)
    begin
      send(16'sh2000, y);
      chk(y == 16'sh1000 || y == -16'sh1000, 1'b1);
      nneg += (y < 0);
    end
    chk(nneg > 0 && nneg < 8, 1'b1);
    // Loud steady input: halved in transmit, doubled and clipped in receive
    host.wr(`OFS_ACTRL, 16'h9000);
    host.wr(`OFS_TX_UNITY, `RST_UNITY);
    host.wr(`OFS_RX_UNITY, `RST_UNITY);
    host.wr(`OFS_CTRL, 16'h0010);
    for (int r = 0; r < 2; r++)
    begin
      rx_mode_i <= 1'(r);
      repeat (4) send(16'sh4000, y);
      chk(y, r ? 16'sh7fff : 16'sh2000);
    end
    // Reset again in mid-run
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host.rd(`OFS_ACTRL, q);
    chk(q, {16'h0, `RST_ACTRL});
    end_of_test();
  end
endmodule : tb_voice_chain
